// file: llm_cal.sv
// Calibration: samples and holds the error-amplifier level after a reference ramp
`include "llm_cfg.svh"
`default_nettype none
module llm_cal
  import llm_pkg::*;
#(
  parameter int LEVEL_W = 8
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ramp_busy,
  input  wire logic [LEVEL_W-1:0] amp_level,
  output logic                    cal_done,
  output logic      [LEVEL_W-1:0] cal_level
);
  localparam logic [3:0] SETTLE = 4'(`LLM_CAL_DELAY_CYC);

  llm_cal_e   state;
  llm_cal_e   next_state;
  logic [3:0] settle_cnt;

  // ****************************************************************************
  // Sequencer
  // ****************************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      LLM_CAL_WAIT:   if (!ramp_busy) next_state = LLM_CAL_SETTLE;
      LLM_CAL_SETTLE: if (ramp_busy) next_state = LLM_CAL_WAIT;
                      else if (settle_cnt == SETTLE) next_state = LLM_CAL_HOLD;
      LLM_CAL_HOLD:   if (ramp_busy) next_state = LLM_CAL_WAIT;
      default:        next_state = LLM_CAL_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state      <= LLM_CAL_WAIT;
      settle_cnt <= 4'h0;
      cal_level  <= '0;
    end else begin
      state      <= next_state;
      settle_cnt <= (state == LLM_CAL_SETTLE) ? settle_cnt + 4'h1 : 4'h0;
      // Sample taken once, shortly after the ramp ends
      if (state == LLM_CAL_SETTLE && next_state == LLM_CAL_HOLD) begin
        cal_level <= amp_level;
      end
    end
  end

  // A new ramp invalidates the held level at once
  assign cal_done = (state == LLM_CAL_HOLD) && !ramp_busy;

  chk_cal_after_settle:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(cal_done) |-> $past(state) == LLM_CAL_SETTLE)
    else $error("calibration held without settle");
endmodule : llm_cal
`default_nettype wire

// file: llm_cfg.svh
// Constants for the light-load mode controller: offsets, fields, resets, timing counts
`ifndef LLM_CFG_SVH
`define LLM_CFG_SVH

// ****************************************************************************
// Register offsets (byte address, word index = address / 4)
// ****************************************************************************
`define LLM_REG_CTRL         8'h00
`define LLM_REG_STATUS       8'h04
`define LLM_REG_CAL_LEVEL    8'h08
`define LLM_REG_ON_TIME      8'h0C

// ****************************************************************************
// Control fields
// ****************************************************************************
`define LLM_CTRL_DIGITAL_BIT 0
`define LLM_CTRL_LLSEL_BIT   1
`define LLM_CTRL_RESET       8'h00

// ****************************************************************************
// Status fields
// ****************************************************************************
`define LLM_ST_LIGHT_BIT     0
`define LLM_ST_CAL_BIT       1
`define LLM_ST_TRACK_BIT     2
`define LLM_ST_BLOCK_BIT     3
`define LLM_ST_PHASE_LSB     4

// ****************************************************************************
// Counts and timing
// ****************************************************************************
`define LLM_ENTRY_COUNT      4'h8
`define LLM_EXIT_COUNT       2'h3
`define LLM_ON_TIME_RESET    8'h05
`define LLM_CAL_DELAY_NS     1000
`define LLM_CLK_PERIOD_NS    100
`define LLM_CAL_DELAY_CYC    ((`LLM_CAL_DELAY_NS + `LLM_CLK_PERIOD_NS - 1) / `LLM_CLK_PERIOD_NS)

`endif

// file: llm_ctrl.sv
// Light-load mode controller of a synchronous buck regulator
//
// Chosen here: the register offsets and the strobed register port.
`include "llm_cfg.svh"
`default_nettype none

// Notes on behaviour
// - Analog mode allows light load only while the enable pin is above 4V.
// - Digital mode allows light load per the light-load select command bit.
// - After the reference ramp, sample the amplifier level, store it, output it.
// - No light-load entry until calibration has stored the amplifier level.
// - Enter light load after zero crossings in 8 consecutive switching cycles.
// - In light load, fixed-width high pulse, then low side on to zero current.
// - After zero current both drivers off until output falls to reference.
// - Return to pulse-width operation when output falls to 95% of reference.
// - Return when output stays below reference through 3 consecutive zero crossings.
// - Output at reference with current still positive defers the pulse to zero.
// - Tracking mode disables light load; continuous conduction only.
// - A new commanded voltage blocks light load until ramp ends and recalibration.
// - Track-select pin low selects tracking; pulled to 1.8V rail selects non-tracking.
module llm_ctrl
  import llm_pkg::*;
#(
  parameter int LEVEL_W = 8,
  parameter int ENTRY_N = 8,
  parameter int EXIT_N  = 3
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  // Pin-level and comparator inputs
  input  wire logic               enable_and_light_load_pin,
  input  wire logic               track_select_pin,
  input  wire logic               pwm_cycle_start,
  input  wire logic               pwm_high_req,
  input  wire logic               current_zero,
  input  wire logic               below_reference,
  input  wire logic               below_95pct,
  input  wire logic               reference_ramp_busy,
  input  wire logic [LEVEL_W-1:0] amp_level,
  // Outputs
  output logic                    high_side_gate_drive,
  output logic                    low_side_gate_drive,
  output logic                    adaptive_light_load_mode,
  output logic      [LEVEL_W-1:0] cal_level_out
);
  // ****************************************************************************
  // Synchronised pin and comparator inputs
  // ****************************************************************************
  logic [7:0] raw_in;
  logic [7:0] syn_in;
  logic       en_ll_pin;
  logic       track_pin;
  logic       cyc_start;
  logic       pwm_high;
  logic       izero;
  logic       below_ref;
  logic       below_95;
  logic       ramp_busy;

  assign raw_in = {enable_and_light_load_pin, track_select_pin, pwm_cycle_start,
                   pwm_high_req, current_zero, below_reference, below_95pct,
                   reference_ramp_busy};

  llm_sync #(.WIDTH(8)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  assign en_ll_pin = syn_in[7];
  assign track_pin = syn_in[6];
  assign cyc_start = syn_in[5];
  assign pwm_high  = syn_in[4];
  assign izero     = syn_in[3];
  assign below_ref = syn_in[2];
  assign below_95  = syn_in[1];
  assign ramp_busy = syn_in[0];

  // ****************************************************************************
  // Edge detection on synchronised signals
  // ****************************************************************************
  logic cyc_start_d;
  logic izero_d;
  logic cyc_edge;
  logic zero_edge;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cyc_start_d <= 1'b0;
      izero_d     <= 1'b0;
    end else begin
      cyc_start_d <= cyc_start;
      izero_d     <= izero;
    end
  end

  assign cyc_edge  = cyc_start && !cyc_start_d;
  assign zero_edge = izero && !izero_d;

  // ****************************************************************************
  // Calibration
  // ****************************************************************************
  logic cal_done;

  llm_cal #(.LEVEL_W(LEVEL_W)) u_cal (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ramp_busy (ramp_busy),
    .amp_level (amp_level),
    .cal_done  (cal_done),
    .cal_level (cal_level_out)
  );

  // ****************************************************************************
  // Registers
  // ****************************************************************************
  logic [7:0] ctrl;
  logic [7:0] on_time;
  logic       digital_mode;
  logic       light_load_select_command;
  logic       wr_ctrl;
  logic       wr_on_time;

  assign wr_ctrl    = reg_wr && (reg_addr == `LLM_REG_CTRL);
  assign wr_on_time = reg_wr && (reg_addr == `LLM_REG_ON_TIME);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl    <= `LLM_CTRL_RESET;
      on_time <= `LLM_ON_TIME_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata[7:0];
      end
      if (wr_on_time) begin
        on_time <= reg_wdata[7:0];
      end
    end
  end

  assign digital_mode              = ctrl[`LLM_CTRL_DIGITAL_BIT];
  assign light_load_select_command = ctrl[`LLM_CTRL_LLSEL_BIT];

  // ****************************************************************************
  // Permission for light load
  // ****************************************************************************
  logic tracking;
  logic ll_requested;
  logic ll_allowed;

  // Pin low means tied to local ground
  assign tracking     = !track_pin;
  // Pin comparator reports the 4V threshold as a logic level
  assign ll_requested = digital_mode ? light_load_select_command : en_ll_pin;
  // Ramp blocks in both modes; calibration drops with every ramp
  assign ll_allowed   = ll_requested && !tracking && cal_done && !ramp_busy;

  // ****************************************************************************
  // Zero-crossing counters
  // ****************************************************************************
  llm_phase_e phase;
  llm_phase_e next_phase;
  logic [3:0] entry_cnt;
  logic [1:0] exit_cnt;
  logic       seen_zero;
  logic       enter_ll;
  logic       exit_ll;

  localparam logic [3:0] ENTRY_LIM = 4'(ENTRY_N);
  localparam logic [1:0] EXIT_LIM  = 2'(EXIT_N);

  assign enter_ll = (phase == LLM_PWM) && ll_allowed && (entry_cnt == ENTRY_LIM);
  // Exit on sag, on repeated low crossings, or once permission is withdrawn
  assign exit_ll  = (phase != LLM_PWM) &&
                    (below_95 || (exit_cnt == EXIT_LIM) || !ll_allowed);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      entry_cnt <= 4'h0;
      seen_zero <= 1'b0;
    end else if (phase != LLM_PWM || exit_ll) begin
      entry_cnt <= 4'h0;
      seen_zero <= 1'b0;
    end else if (cyc_edge) begin
      // Cycle closes: count if it saw a crossing, else restart
      if (seen_zero || zero_edge) begin
        entry_cnt <= (entry_cnt == ENTRY_LIM) ? entry_cnt : entry_cnt + 4'h1;
      end else begin
        entry_cnt <= 4'h0;
      end
      seen_zero <= 1'b0;
    end else if (zero_edge) begin
      seen_zero <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exit_cnt <= 2'h0;
    end else if (phase == LLM_PWM) begin
      exit_cnt <= 2'h0;
    end else if (zero_edge) begin
      if (below_ref) begin
        exit_cnt <= (exit_cnt == EXIT_LIM) ? exit_cnt : exit_cnt + 2'h1;
      end else begin
        exit_cnt <= 2'h0;
      end
    end
  end

  // ****************************************************************************
  // Drive sequencer
  // ****************************************************************************
  logic [7:0] pulse_cnt;
  logic       pulse_end;

  assign pulse_end = (pulse_cnt >= on_time);

  always_comb begin
    next_phase = phase;
    unique case (phase)
      LLM_PWM:     if (enter_ll) next_phase = LLM_IDLE;
      LLM_PULSE:   if (exit_ll) next_phase = LLM_PWM;
                   else if (pulse_end) next_phase = LLM_EMULATE;
      LLM_EMULATE: if (exit_ll) next_phase = LLM_PWM;
                   // Edge, not level: the synced level is stale right after a short pulse
                   else if (zero_edge) next_phase = LLM_IDLE;
      LLM_IDLE:    if (exit_ll) next_phase = LLM_PWM;
                   // New pulse only once output sags and current is zero
                   else if (below_ref && izero) next_phase = LLM_PULSE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase     <= LLM_PWM;
      pulse_cnt <= 8'h00;
    end else begin
      phase     <= next_phase;
      pulse_cnt <= (next_phase == LLM_PULSE) ? pulse_cnt + 8'h01 : 8'h00;
    end
  end

  // Drivers registered; continuous conduction mirrors the modulator
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      high_side_gate_drive     <= 1'b0;
      low_side_gate_drive      <= 1'b0;
      adaptive_light_load_mode <= 1'b0;
    end else begin
      high_side_gate_drive     <= (next_phase == LLM_PWM) ? pwm_high
                                                          : (next_phase == LLM_PULSE);
      low_side_gate_drive      <= (next_phase == LLM_PWM) ? !pwm_high
                                                          : (next_phase == LLM_EMULATE);
      adaptive_light_load_mode <= (next_phase != LLM_PWM);
    end
  end

  // ****************************************************************************
  // Read path
  // ****************************************************************************
  logic [31:0] next_rdata;
  logic [7:0]  status;

  assign status = {2'b00, phase, !ll_allowed, tracking, cal_done, phase != LLM_PWM};
  assign next_rdata =
    (reg_addr == `LLM_REG_CTRL)      ? {24'h000000, ctrl} :
    (reg_addr == `LLM_REG_STATUS)    ? {24'h000000, status} :
    (reg_addr == `LLM_REG_CAL_LEVEL) ? 32'(cal_level_out) :
    (reg_addr == `LLM_REG_ON_TIME)   ? {24'h000000, on_time} : 32'h00000000;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  chk_entry_needs_cal:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_PWM && next_phase != LLM_PWM) |-> cal_done && entry_cnt == ENTRY_LIM)
    else $error("light load entered without calibration or eight crossings");

  chk_track_blocks_ll:
    assert property (@(posedge ref_clk) disable iff (rst)
      tracking |=> phase == LLM_PWM)
    else $error("light load active during tracking");

  chk_sag_exits:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase != LLM_PWM && below_95) |=> phase == LLM_PWM)
    else $error("no return on 95 percent sag");

  chk_exit_count:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase != LLM_PWM && exit_cnt == EXIT_LIM) |=> phase == LLM_PWM)
    else $error("no return after three low crossings");

  chk_pulse_deferred:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_IDLE && !izero) |=> phase != LLM_PULSE)
    else $error("pulse started with current flowing");

  chk_idle_drivers_off:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_IDLE && next_phase == LLM_IDLE) |=> !high_side_gate_drive && !low_side_gate_drive)
    else $error("driver on while idle");

  chk_zero_clear_exit:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase != LLM_PWM && zero_edge && !below_ref) |=> exit_cnt == 2'h0)
    else $error("exit counter not cleared");

  chk_no_ramp_ll:
    assert property (@(posedge ref_clk) disable iff (rst)
      ramp_busy |=> phase == LLM_PWM)
    else $error("light load during reference ramp");

  chk_emulate_holds_low:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_EMULATE && !zero_edge && !exit_ll) |=> low_side_gate_drive && !high_side_gate_drive)
    else $error("low side released before zero current");

  chk_entry_cnt_clear:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_PWM && cyc_edge && !seen_zero && !zero_edge) |=> entry_cnt == 4'h0)
    else $error("entry counter kept after a cycle without crossing");

  chk_ll_needs_permit:
    assert property (@(posedge ref_clk) disable iff (rst)
      (phase == LLM_PWM && !ll_requested) |=> phase == LLM_PWM)
    else $error("light load entered without pin or command permit");
endmodule : llm_ctrl
`default_nettype wire

// file: llm_pkg.sv
// Types shared by the light-load mode controller
`default_nettype none
package llm_pkg;
  typedef enum logic [1:0] {
    LLM_PWM      = 2'b00,
    LLM_PULSE    = 2'b01,
    LLM_EMULATE  = 2'b10,
    LLM_IDLE     = 2'b11
  } llm_phase_e;

  typedef enum logic [1:0] {
    LLM_CAL_WAIT   = 2'b00,
    LLM_CAL_SETTLE = 2'b01,
    LLM_CAL_HOLD   = 2'b10
  } llm_cal_e;
endpackage : llm_pkg
`default_nettype wire

// file: llm_stage_model.sv
// Behavioural power stage and output comparators facing the mode controller
`default_nettype none
module llm_stage_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic high_side_gate_drive,
  input  wire logic low_side_gate_drive,
  input  wire logic light,
  input  wire logic heavy,
  input  wire logic sag,
  output logic      pwm_cycle_start,
  output logic      pwm_high_req,
  output logic      current_zero,
  output logic      below_reference,
  output logic      below_95pct
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // Inductor current and output level, in coarse integer steps
  // ************************************************************
  int cnt;
  int cur;
  int v;
  int tick;
  always @(posedge ref_clk or posedge rst) begin
    int nv;
    if (rst) begin
      cnt <= 0;
      cur <= 0;
      v <= 110;
      tick <= 0;
    end else begin
      cnt <= (cnt == 9) ? 0 : cnt + 1;
      tick <= tick + 1;
      // Without light set the current never falls back to zero
      if (high_side_gate_drive) begin
        cur <= (cur > 17) ? 20 : cur + 3;
      end else if (low_side_gate_drive && light && cur > -2) begin
        cur <= cur - 1;
      end
      nv = v + ((cur > 0) ? 1 : 0);
      nv = nv - (heavy ? 3 : ((light && tick % 4 == 0) ? 1 : 0));
      // Floor keeps a heavy load below reference but above the sag level
      v <= (nv < 96) ? 96 : ((nv > 120) ? 120 : nv);
    end
  end
  // Comparators always drive; nothing here is ever released
  assign pwm_cycle_start = (cnt == 0);
  assign pwm_high_req    = (cnt == 1) || (cnt == 2);
  assign current_zero    = (cur <= 0);
  assign below_reference = (v < 100);
  assign below_95pct     = sag;
endmodule : llm_stage_model
`default_nettype wire

// file: llm_sync.sv
// Two-flop synchroniser for pin-level inputs
`default_nettype none
module llm_sync
  import llm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : llm_sync
`default_nettype wire

// file: test_light_load_mode_controller.sv
// Self-checking bench for the light-load mode controller
`include "llm_cfg.svh"
`default_nettype none
module test_light_load_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, reg_wr, reg_rd, pin, trk, ramp, light, heavy, sag, mon_en;
  logic [7:0]  reg_addr, amp, cal, on_t;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic        hs, ls, mode, cs, hr, cz, br, b95, hq, lq;
  logic [4:0]  bh, ch;
  int          error_cnt, total_checks, run;

  llm_ctrl u_llm_ctrl (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enable_and_light_load_pin(pin), .track_select_pin(trk), .pwm_cycle_start(cs),
    .pwm_high_req(hr), .current_zero(cz), .below_reference(br), .below_95pct(b95),
    .reference_ramp_busy(ramp), .amp_level(amp), .high_side_gate_drive(hs),
    .low_side_gate_drive(ls), .adaptive_light_load_mode(mode), .cal_level_out(cal));
  llm_stage_model u_llm_stage_model (.ref_clk(ref_clk), .rst(rst),
    .high_side_gate_drive(hs), .low_side_gate_drive(ls), .light(light), .heavy(heavy),
    .sag(sag), .pwm_cycle_start(cs), .pwm_high_req(hr), .current_zero(cz),
    .below_reference(br), .below_95pct(b95));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles
  // Bounded wait; n comes back as the cycles waited for the mode, one more cycle follows
  task automatic wait_mode(input logic want, input int lim, output int n);
    n = 0;
    while (mode !== want && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
  endtask : wait_mode
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Pulse shape watcher while in light-load mode
  always @(posedge ref_clk) begin
    bh <= {bh[3:0], br};
    ch <= {ch[3:0], cz};
    hq <= hs;
    lq <= ls;
    run <= hs ? run + 1 : 0;
    if (mon_en && mode) begin
      if (hq && !hs) begin
        chk("pulse width", on_t, run);
        chk("low side after pulse", 1, ls);
      end
      if (!hq && hs) chk("pulse cause", 1, |(bh & ch));
      if (lq && !ls) chk("low side release", 1, |ch);
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Whole run is some 2500 cycles
  initial begin
    #(20000 * 100);
    error_cnt++;
    wrap_up();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] d;
    int n;
    {rst, trk, ramp} = 3'b111;
    {reg_wr, reg_rd, pin, light, heavy, sag, mon_en} = 7'h00;
    {reg_addr, amp, reg_wdata} = '0;
    seed = 32'h8a137d6d;
    on_t = `LLM_ON_TIME_RESET;
    error_cnt = 0;
    total_checks = 0;
    cycles(2);
    rst <= 1'b0;
    chk("outputs at reset", 0, {hs, ls, mode, cal});
    rd(`LLM_REG_CTRL, d);
    chk("control reset", `LLM_CTRL_RESET, d);
    rd(`LLM_REG_ON_TIME, d);
    chk("on time reset", `LLM_ON_TIME_RESET, d);
    wr(8'h40, 32'hFF);
    rd(8'h40, d);
    chk("unmapped read", 0, d);
    $display("done: reset");
    seed = lfsr(seed);
    amp <= seed[7:0];
    {light, pin} <= 2'b11;
    cycles(300);
    chk("mode before calibration", 0, mode);
    light <= 1'b0;
    ramp <= 1'b0;
    cycles(5);
    rd(`LLM_REG_STATUS, d);
    chk("cal flag early", 0, d[`LLM_ST_CAL_BIT]);
    cycles(12);
    chk("cal level out", amp, cal);
    rd(`LLM_REG_STATUS, d);
    chk("cal flag", 1, d[`LLM_ST_CAL_BIT]);
    rd(`LLM_REG_CAL_LEVEL, d);
    chk("cal register", amp, d);
    $display("done: calibration");
    {pin, light} <= 2'b01;
    cycles(250);
    chk("pin low blocks", 0, mode);
    // Clear the saturated entry count before the permit appears
    light <= 1'b0;
    cycles(40);
    {pin, light} <= 2'b11;
    wait_mode(1, 400, n);
    chk("entry cycles", 1, n >= 70 && n <= 300);
    $display("done: entry after %0d cycles", n);
    mon_en <= 1'b1;
    cycles(400);
    mon_en <= 1'b0;
    seed = lfsr(seed);
    on_t = 8'h02 + {5'h0, seed[2:0]};
    wr(`LLM_REG_ON_TIME, {24'h0, on_t});
    cycles(30);
    mon_en <= 1'b1;
    cycles(400);
    mon_en <= 1'b0;
    chk("still light load", 1, mode);
    $display("done: light-load pulses, on time %0d", on_t);
    sag <= 1'b1;
    wait_mode(0, 10, n);
    chk("exit on sag", 0, mode);
    sag <= 1'b0;
    wait_mode(1, 400, n);
    chk("re-entry cycles", 1, n >= 70 && n <= 300);
    heavy <= 1'b1;
    wait_mode(0, 300, n);
    chk("exit below reference", 0, mode);
    heavy <= 1'b0;
    wait_mode(1, 400, n);
    $display("done: exits");
    trk <= 1'b0;
    wait_mode(0, 10, n);
    cycles(250);
    chk("tracking blocks", 0, mode);
    rd(`LLM_REG_STATUS, d);
    chk("tracking flag", 1, d[`LLM_ST_TRACK_BIT]);
    trk <= 1'b1;
    wait_mode(1, 400, n);
    chk("entry after tracking", 1, mode);
    $display("done: tracking");
    wr(`LLM_REG_CTRL, 32'h1);
    wait_mode(0, 10, n);
    cycles(250);
    chk("digital deselected", 0, mode);
    wr(`LLM_REG_CTRL, 32'h3);
    wait_mode(1, 400, n);
    chk("digital selected", 1, mode);
    ramp <= 1'b1;
    wait_mode(0, 10, n);
    rd(`LLM_REG_STATUS, d);
    chk("blocked flag", 1, d[`LLM_ST_BLOCK_BIT]);
    seed = lfsr(seed);
    amp <= seed[7:0];
    cycles(100);
    chk("ramp blocks", 0, mode);
    ramp <= 1'b0;
    cycles(16);
    chk("recalibrated level", amp, cal);
    wait_mode(1, 400, n);
    chk("entry after ramp", 1, mode);
    $display("done: digital and ramp");
    wrap_up();
  end
endmodule : test_light_load_mode_controller
`default_nettype wire
